// file: sim/encoder_model.sv
// Sector encoder stand-in: takes framer bytes with a valid/ready handshake.
// Assumes one clock; slow mode makes ready drop at random cycles.
`timescale 1ns/1ps

module encoder_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    input  wire logic out_valid,
    output logic      out_ready
);
    // Ready changes only after an edge, so a stall never splits a byte
    // Bytes are swallowed without interpreting manufacturing content
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= slow ? ($urandom_range(2) != 0) : 1'b1;
        end
    end
endmodule : encoder_model

// file: sim/tb.sv
// Self-checking bench for the lead-in framer: APB, byte stream, receive checker.
// Assumes leadin_regs.svh offsets and the zero-wait APB slave of the design.
`timescale 1ns/1ps
`include "leadin_regs.svh"

module tb;
    import leadin_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, bout, bin;
    logic        out_valid, out_ready, out_first, out_last, out_scramble, out_guard, out_prerec;
    logic        rx_valid, rx_first, single, s80, bca, lead;
    logic [7:0]  out_data, rx_byte;
    logic [23:0] out_sector, last;
    logic [3:0]  rate;
    int          errors, total_checks, pos, sec;
    logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'hf, 4'h5};
    int          bad_pos [7] = '{-1, 0, 1, 2, 16, 40, 1};
    logic [7:0]  bad_val [7] = '{8'h00, 8'h26, 8'h25, 8'h12, 8'h01, 8'h01, 8'h03};

    lead_in_format_info_framer lead_in_format_info_framer_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_first(out_first), .out_last(out_last),
        .out_scramble(out_scramble), .out_guard(out_guard), .out_prerec(out_prerec),
        .out_sector(out_sector), .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte));
    encoder_model encoder_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready));

    // ------------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] pfi(input int p);
        case (p)
            0: return 8'h25;
            1: return {3'b000, s80, rate};
            2: return 8'h02;
            5: return 8'h03;
            9, 10, 11: return last[8*(11-p) +: 8];
            16: return {bca, 7'h00};
            32, 33, 34, 35: return single ? 8'h00 : bout[8*(35-p) +: 8];
            36, 37, 38, 39: return single ? 8'h00 : bin[8*(39-p) +: 8];
            default: return 8'h00;
        endcase
    endfunction : pfi

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic conclude();
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin chk(0, 1, "apb timeout"); conclude(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Bounded wait for n complete sectors on the stream
    task automatic wait_sec(input int n);
        int k;
        k = 0;
        while (sec < n && k < 30000) begin @(posedge pclk); k++; end
        if (k >= 30000) begin chk(0, 1, "stream timeout"); conclude(); end
    endtask : wait_sec

    // Received sector with one byte optionally corrupted; idle bus toggles
    task automatic rx_send(input int bad, input logic [7:0] v);
        for (int p = 0; p < 2048; p++) begin
            rx_valid <= 1'b1; rx_first <= (p == 0); rx_byte <= (p == bad) ? v : pfi(p);
            @(posedge pclk);
        end
        rx_valid <= 1'b0; rx_byte <= ~rx_byte;
        @(posedge pclk);
    endtask : rx_send

    // ------------------------------------------------------------------
    // Stream monitor: every accepted byte against the model
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        if (presetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            chk(out_data, lead ? 8'hac : pfi(pos), "data");
            chk(out_first, pos == 0, "first");
            chk(out_last, pos == 2047, "last");
            chk(out_scramble, lead ? (pos < 160 && sec % 16 == 0) : 1'b1, "scramble");
            chk(out_sector, lead ? 24'h02f000 + sec : 24'h0, "sector");
            chk({out_guard, out_prerec}, 0, "zone flags");
            if (pos == 2047) begin pos = 0; sec++; end else pos++;
        end
    end

    initial begin pclk = 1'b0; forever #25 pclk = ~pclk; end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h4c54c9b2));
        {presetn, psel, penable, pwrite, rx_valid, rx_first, slow, lead} = '0;
        {paddr, pwdata, rx_byte, errors, total_checks, pos, sec} = '0;
        {single, s80, bca, last, bout, bin} = '0; rate = 4'hf;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `OFS_CTRL, 0); chk(rd, 32'hf0, "ctrl reset");
        apb(0, `OFS_STATUS, 0); chk(rd, {ST_IDLE, 2'b00}, "status reset");
        apb(0, 12'h014, 0); chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        // Every rate code plus an illegal one, both modes and sizes
        for (int i = 0; i < 5; i++) begin
            single = i[0]; s80 = i[1]; slow = i[0] ^ i[1]; bca = $urandom;
            last = $urandom; bout = $urandom; bin = $urandom;
            rate = (codes[i] == 4'h5) ? 4'hf : codes[i];
            apb(1, `OFS_LAST_ADDR, {8'h00, last});
            apb(1, `OFS_BORDER_OUT, bout);
            apb(1, `OFS_BORDER_IN, bin);
            pos = 0; sec = 0;
            apb(1, `OFS_CTRL, {23'h0, bca, codes[i], s80, single, 2'b01});
            apb(0, `OFS_STATUS, 0); chk(rd, {ST_PFI, 2'b01}, "busy format");
            wait_sec(1);
            @(posedge pclk); chk(out_valid, 0, "sector end");
            apb(0, `OFS_CTRL, 0); chk(rd, {23'h0, bca, rate, s80, single, 2'b00}, "ctrl");
        end
        // Lead-in: two reference sectors, then reset in mid-run
        pos = 0; sec = 0; lead = 1'b1; slow = 1'b1;
        apb(1, `OFS_CTRL, 32'h0000_00f2);
        apb(0, `OFS_STATUS, 0); chk(rd, {ST_REF, 2'b01}, "busy ref");
        // A start while busy must be ignored; reference bytes do not use the config
        apb(1, `OFS_CTRL, 32'h0000_00f1);
        apb(0, `OFS_STATUS, 0); chk(rd, {ST_REF, 2'b01}, "start refused");
        wait_sec(2);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(out_valid, 0, "reset stream");
        presetn <= 1'b1; lead = 1'b0;
        @(posedge pclk);
        apb(0, `OFS_CTRL, 0); chk(rd, 32'hf0, "ctrl after reset");
        apb(0, `OFS_STATUS, 0); chk(rd, {ST_IDLE, 2'b00}, "status after reset");
        // Receive checker: clean sector, then one bad field at a time
        for (int j = 0; j < 7; j++) begin
            rx_send(bad_pos[j], bad_val[j]);
            apb(0, `OFS_STATUS, 0); chk(rd[1], j != 0, "fmt err");
            apb(1, `OFS_STATUS, 32'h2);
            apb(0, `OFS_STATUS, 0); chk(rd[1], 0, "fmt clear");
        end
        conclude();
    end
endmodule : tb

// file: src/lead_in_format_info_framer.sv
// Lead-in sector framer: format information sector, reference code, buffer 1, control data.
// Assumes an APB master on pclk and a sector encoder that takes one byte per
// cycle with valid/ready; scrambling and ECC are done downstream.
//
// Overview of operation
// - Format sector is 2048 bytes, fixed field positions
// - Byte 0 is category 0010, version 0101
// - Byte 1 low nibble is rate code
// - Byte 1 high nibble: 120 mm or 80 mm
// - Byte 2 layer type 0010, rest zero
// - Byte 3 is zero: pitch and bit length
// - Bytes 4-8 give data zone start 030000
// - Bytes 9-11 last recorded or end address
// - Unused byte ranges are driven zero
// - Byte 16 bit 7 flags barcode area
// - Incremental mode: border-out and next border-in
// - Single pass mode: bytes 32-39 zero
// - Reference zone: 32 sectors of AC bytes
// - Reference zone unscrambled except first 160 bytes of each block's sector 0
// - Buffer 1: 480 zero sectors, last block guard
// - Pre-recorded area starts at control data zone, after guard
// - Control data zone: 192 blocks from 193024
// - Block sector 0 format info, sector 1 manufacturing
// - Pre-recorded variant points at extra border zone
// - Pre-recorded bytes 32-39: 02FE10 and 02FFA0
// - ECC block is 16 sectors
`timescale 1ns/1ps
`include "leadin_regs.svh"

module lead_in_format_info_framer (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic      [7:0]           out_data,
    output logic                      out_first,
    output logic                      out_last,
    output logic                      out_scramble,
    output logic                      out_guard,
    output logic                      out_prerec,
    output logic      [23:0]          out_sector,
    input  wire logic                 rx_valid,
    input  wire logic                 rx_first,
    input  wire logic [7:0]           rx_byte
);
    import leadin_pkg::*;

    // ------------------------------------------------------------------------
    // Field encoding and checking
    // ------------------------------------------------------------------------
    // Byte of a format information sector at a position
    function automatic logic [7:0] pfi_byte(input logic [10:0] pos, input logic prerec,
                                            input logic single, input logic size80,
                                            input logic [3:0] rate, input logic bca,
                                            input logic [23:0] last, input logic [31:0] bout,
                                            input logic [31:0] bin);
        logic [31:0] w;
        w = 32'h0;
        if (prerec)
            w = (pos < 11'd36) ? `PRE_RECMGMT_START : `PRE_PFI_START;
        else if (!single)
            w = (pos < 11'd36) ? bout : bin;
        case (pos)
            11'd0:   pfi_byte = `CAT_VERSION;
            11'd1:   pfi_byte = {3'b000, size80, rate};
            11'd2:   pfi_byte = `STRUCT_CODE;
            11'd5:   pfi_byte = `DATA_START_MID;
            11'd9:   pfi_byte = last[23:16];
            11'd10:  pfi_byte = last[15:8];
            11'd11:  pfi_byte = last[7:0];
            11'd16:  pfi_byte = {bca, 7'h00};
            11'd32, 11'd33, 11'd34, 11'd35, 11'd36, 11'd37, 11'd38, 11'd39:
                     pfi_byte = w[{~pos[1:0], 3'b000} +: 8];
            default: pfi_byte = 8'h00;
        endcase
    endfunction : pfi_byte

    // Whether a received byte holds a permitted code at its position
    function automatic logic pfi_legal(input logic [10:0] pos, input logic [7:0] b);
        case (pos)
            11'd0:   pfi_legal = (b == `CAT_VERSION);
            11'd1:   pfi_legal = (b[7:5] == 3'b000) && ((b[3:0] == `RATE_2M52) ||
                                 (b[3:0] == `RATE_5M04) || (b[3:0] == `RATE_10M08) ||
                                 (b[3:0] == `RATE_UNSPEC));
            11'd2:   pfi_legal = (b == `STRUCT_CODE);
            11'd5:   pfi_legal = (b == `DATA_START_MID);
            11'd9, 11'd10, 11'd11, 11'd32, 11'd33, 11'd34, 11'd35, 11'd36, 11'd37,
            11'd38, 11'd39:
                     pfi_legal = 1'b1;
            11'd16:  pfi_legal = ((b & `BARCODE_RSV_MASK) == 8'h00);
            default: pfi_legal = (b == 8'h00);
        endcase
    endfunction : pfi_legal

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic        single_reg;
    logic        size80_reg;
    logic [3:0]  rate_reg;
    logic        bca_reg;
    logic [23:0] last_reg;
    logic [31:0] bout_reg;
    logic [31:0] bin_reg;
    logic        fmt_err_reg;
    logic        go_pfi;
    logic        go_leadin;
    logic        wr_acc;
    logic [3:0]  rate_next;
    zone_t       state_reg;
    logic [11:0] sec_reg;
    logic [10:0] pos_reg;
    logic [10:0] rx_pos_reg;
    logic [10:0] opos_reg;
    zone_t       ozone_reg;
    logic        ld;
    logic        mapped;

    assign wr_acc    = psel && penable && pready && pwrite;
    assign go_pfi    = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_START_PFI];
    assign go_leadin = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_START_LEADIN];
    assign mapped    = (paddr == `OFS_CTRL) || (paddr == `OFS_LAST_ADDR) ||
                       (paddr == `OFS_BORDER_OUT) || (paddr == `OFS_BORDER_IN) ||
                       (paddr == `OFS_STATUS);
    // Only permitted rate codes are stored, anything else means unspecified
    assign rate_next = (pwdata[7:4] <= `RATE_10M08) ? pwdata[7:4] : `RATE_UNSPEC;

    // APB answer: one wait-free access phase, read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            case (paddr)
                `OFS_CTRL:       prdata <= {23'h0, bca_reg, rate_reg, size80_reg,
                                            single_reg, 2'b00};
                `OFS_LAST_ADDR:  prdata <= {8'h00, last_reg};
                `OFS_BORDER_OUT: prdata <= bout_reg;
                `OFS_BORDER_IN:  prdata <= bin_reg;
                `OFS_STATUS:     prdata <= {25'h0, state_reg, fmt_err_reg,
                                            (state_reg != ST_IDLE)};
                default:         prdata <= 32'h0;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration writes; the size field is a single bit so no other code exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_reg <= 1'b0;
            size80_reg <= 1'b0;
            rate_reg   <= `RATE_UNSPEC;
            bca_reg    <= 1'b0;
            last_reg   <= 24'h0;
            bout_reg   <= 32'h0;
            bin_reg    <= 32'h0;
        end else if (wr_acc) begin
            case (paddr)
                `OFS_CTRL: begin
                    single_reg <= pwdata[`CTRL_SINGLE_PASS];
                    size80_reg <= pwdata[`CTRL_SIZE_80MM];
                    rate_reg   <= rate_next;
                    bca_reg    <= pwdata[`CTRL_BARCODE];
                end
                `OFS_LAST_ADDR:  last_reg <= pwdata[23:0];
                `OFS_BORDER_OUT: bout_reg <= pwdata;
                `OFS_BORDER_IN:  bin_reg  <= pwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Zone sequencer
    // ------------------------------------------------------------------------
    // Output register may take a new byte when empty or being drained
    assign ld = !out_valid || out_ready;

    logic sec_end;
    assign sec_end = (pos_reg == 11'(`SECTOR_BYTES - 12'd1));

    // Walk bytes then sectors; zone order reference, buffer 1, control data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            sec_reg   <= 12'h0;
            pos_reg   <= 11'h0;
        end else if (state_reg == ST_IDLE) begin
            pos_reg <= 11'h0;
            sec_reg <= 12'h0;
            if (go_leadin)
                state_reg <= ST_REF;
            else if (go_pfi)
                state_reg <= ST_PFI;
        end else if (ld) begin
            pos_reg <= pos_reg + 11'd1;
            if (sec_end) begin
                sec_reg <= sec_reg + 12'd1;
                case (state_reg)
                    ST_PFI: state_reg <= ST_IDLE;
                    ST_REF: if (sec_reg == `REF_SECTORS - 12'd1) begin
                        state_reg <= ST_BUF;
                        sec_reg   <= 12'h0;
                    end
                    ST_BUF: if (sec_reg == `BUF1_SECTORS - 12'd1) begin
                        state_reg <= ST_CDZ;
                        sec_reg   <= 12'h0;
                    end
                    ST_CDZ: if (sec_reg == `CDZ_SECTORS - 12'd1)
                        state_reg <= ST_IDLE;
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Byte content of the current slot
    logic [7:0]  byte_now;
    logic [23:0] psn_now;
    logic        blk0;
    assign blk0 = (sec_reg[3:0] == 4'h0);
    always_comb begin
        byte_now = 8'h00;
        psn_now  = 24'h0;
        case (state_reg)
            ST_PFI: byte_now = pfi_byte(pos_reg, 1'b0, single_reg, size80_reg, rate_reg,
                                        bca_reg, last_reg, bout_reg, bin_reg);
            ST_REF: begin
                byte_now = `REF_FILL;
                psn_now  = `PSN_REF + {12'h0, sec_reg};
            end
            ST_BUF: psn_now = `PSN_BUF1 + {12'h0, sec_reg};
            ST_CDZ: begin
                psn_now = `PSN_CDZ + {12'h0, sec_reg};
                // Sector 1 carries manufacturing data; nothing is defined, so zeros
                if (blk0)
                    byte_now = pfi_byte(pos_reg, 1'b1, single_reg, size80_reg, rate_reg,
                                        bca_reg, last_reg, bout_reg, bin_reg);
            end
            default: byte_now = 8'h00;
        endcase
    end

    // Output stage; stalls hold every field stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid    <= 1'b0;
            out_data     <= 8'h00;
            out_first    <= 1'b0;
            out_last     <= 1'b0;
            out_scramble <= 1'b0;
            out_guard    <= 1'b0;
            out_prerec   <= 1'b0;
            out_sector   <= 24'h0;
            opos_reg     <= 11'h0;
            ozone_reg    <= ST_IDLE;
        end else if (ld) begin
            out_valid    <= (state_reg != ST_IDLE);
            out_data     <= byte_now;
            out_first    <= (pos_reg == 11'h0);
            out_last     <= sec_end;
            // Reference frames bypass scrambling except the block-head stretch
            out_scramble <= (state_reg != ST_REF) ||
                            (blk0 && pos_reg < `REF_SCRAMBLE_BYTES);
            // Last block of buffer 1 is the guard area, later linking loss
            out_guard    <= (state_reg == ST_BUF) &&
                            (sec_reg >= `BUF1_SECTORS - `ECC_SECTORS);
            out_prerec   <= (state_reg == ST_CDZ);
            out_sector   <= psn_now;
            opos_reg     <= pos_reg;
            ozone_reg    <= state_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Received format sector checker
    // ------------------------------------------------------------------------
    // Position tracks the incoming sector; the first marker restarts at byte 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rx_pos_reg <= 11'h0;
        else if (rx_valid)
            rx_pos_reg <= rx_first ? 11'd1 : rx_pos_reg + 11'd1;
    end

    // Sticky error, write one to clear; a fresh error wins over the clear
    logic [10:0] rx_pos_now;
    logic        rx_bad;
    assign rx_pos_now = rx_first ? 11'h0 : rx_pos_reg;
    assign rx_bad     = rx_valid && !pfi_legal(rx_pos_now, rx_byte);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fmt_err_reg <= 1'b0;
        else if (rx_bad)
            fmt_err_reg <= 1'b1;
        else if (wr_acc && paddr == `OFS_STATUS && pwdata[`STAT_FMT_ERR])
            fmt_err_reg <= 1'b0;
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic pfi_out;
    assign pfi_out = out_valid && (ozone_reg == ST_PFI || (out_prerec && out_sector[3:0] == 4'h0));

    chk_cat_version: assert property (pfi_out && opos_reg == 11'd0 |-> out_data == 8'h25)
        else $error("category and version byte wrong");
    chk_size_rate: assert property (pfi_out && opos_reg == 11'd1 |->
        out_data[7:5] == 3'b000 && out_data[3:0] == rate_reg)
        else $error("size or rate byte wrong");
    chk_structure: assert property (pfi_out && opos_reg == 11'd2 |-> out_data == 8'h02)
        else $error("structure byte wrong");
    chk_data_start: assert property (pfi_out && opos_reg >= 11'd4 && opos_reg <= 11'd8 |->
        out_data == ((opos_reg == 11'd5) ? 8'h03 : 8'h00))
        else $error("data zone start wrong");
    chk_single_border: assert property (ozone_reg == ST_PFI && out_valid && single_reg &&
        opos_reg >= 11'd32 && opos_reg <= 11'd39 |-> out_data == 8'h00)
        else $error("border field not zero in single pass mode");
    chk_ref_fill: assert property (out_valid && ozone_reg == ST_REF |-> out_data == 8'hac)
        else $error("reference fill wrong");
    chk_ref_scramble: assert property (out_valid && ozone_reg == ST_REF &&
        opos_reg == 11'd160 |-> !out_scramble)
        else $error("reference frame scrambled past head");
    chk_stall_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data) && $stable(opos_reg))
        else $error("byte changed during stall");
    chk_err_sticky: assert property (rx_bad |=> fmt_err_reg [*2])
        else $error("format error flag not held");
    chk_guard: assert property (out_valid && out_sector == 24'h02f1f0 |-> out_guard)
        else $error("guard block not marked");

endmodule : lead_in_format_info_framer

// file: src/leadin_pkg.sv
// Types shared by the lead-in framer.
// Assumes leadin_regs.svh carries the numeric constants.
package leadin_pkg;

    // Zone being emitted, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PFI  = 5'b00010,
        ST_REF  = 5'b00100,
        ST_BUF  = 5'b01000,
        ST_CDZ  = 5'b10000
    } zone_t;

endpackage : leadin_pkg

// file: src/leadin_regs.svh
// Register offsets, field positions, reset values and zone counts of the lead-in framer.
// Included by the framer module; definitions only.
`ifndef LEADIN_REGS_SVH
`define LEADIN_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OFS_CTRL            12'h000
`define OFS_LAST_ADDR       12'h004
`define OFS_BORDER_OUT      12'h008
`define OFS_BORDER_IN       12'h00c
`define OFS_STATUS          12'h010

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define CTRL_START_PFI      0
`define CTRL_START_LEADIN   1
`define CTRL_SINGLE_PASS    2
`define CTRL_SIZE_80MM      3
`define CTRL_RATE_LO        4
`define CTRL_BARCODE        8
`define STAT_BUSY           0
`define STAT_FMT_ERR        1
`define STAT_STATE_LO       2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define RATE_2M52           4'h0
`define RATE_5M04           4'h1
`define RATE_10M08          4'h2
`define RATE_UNSPEC         4'hf
`define CAT_VERSION         8'h25
`define STRUCT_CODE         8'h02
`define DATA_START_MID      8'h03
`define BARCODE_RSV_MASK    8'h7f
`define REF_FILL            8'hac
`define PRE_RECMGMT_START   32'h0002fe10
`define PRE_PFI_START       32'h0002ffa0

// ----------------------------------------------------------------------------
// Zone geometry in sectors, byte positions
// ----------------------------------------------------------------------------
`define SECTOR_BYTES        12'd2048
`define ECC_SECTORS         12'd16
`define REF_SECTORS         12'd32
`define BUF1_SECTORS        12'd480
`define CDZ_SECTORS         12'd3072
`define REF_SCRAMBLE_BYTES  11'd160
`define PSN_REF             24'h02f000
`define PSN_BUF1            24'h02f020
`define PSN_CDZ             24'h02f200

`endif
